// [src/scc_pkg.sv]
package scc_pkg;

  // Register word indices, byte address is four times the index
  localparam logic [9:0] IDX_CTRL      = 10'h030;
  localparam logic [9:0] IDX_STATUS    = 10'h031;
  localparam logic [9:0] IDX_CTRL_TWO  = 10'h032;
  localparam logic [9:0] IDX_IRQ_STAT  = 10'h038;
  localparam logic [9:0] IDX_IRQ_MASK  = 10'h039;

  // Control register fields
  localparam int CTRL_RCVR_ON_BIT   = 7;
  localparam int CTRL_PROC_ON_BIT   = 6;
  localparam int CTRL_EDGE_CLR_BIT  = 5;
  localparam int CTRL_MARG_CLR_BIT  = 4;
  localparam int CTRL_DEVICE_SAMPLE_CLOCK_DC_BIT = 2;
  localparam int CTRL_ALIGN_DC_BIT  = 1;
  localparam int CTRL_SYNC_DC_BIT   = 0;

  // Status register fields
  localparam int STAT_EDGE_BIT = 7;
  localparam int STAT_MARG_BIT = 6;
  localparam logic [5:0] STAT_FIXED_LOW = 6'h07;

  // Reset values
  localparam logic [7:0] CTRL_RESET     = 8'hC0;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h80;

  // Interrupt bit positions
  localparam int IRQ_EDGE_BIT = 0;
  localparam int IRQ_MARG_BIT = 1;

  // Avalon-MM request bundle
  typedef struct packed {
    logic [11:0] address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } scc_avmm_req_t;

  // Avalon-MM answer bundle
  typedef struct packed {
    logic [31:0] readdata;
    logic        readdatavalid;
    logic        waitrequest;
  } scc_avmm_rsp_t;

  // Bus handshake states
  typedef enum logic [0:0] {
    SCC_IDLE = 1'b0,
    SCC_DONE = 1'b1
  } scc_bus_state_t;

endpackage

// [src/scc_sysref_capture_control.sv]
`timescale 1ns/10ps
// Behaviour
// RULE_01 - Control bit 7 enables receiver, resets 1
// RULE_02 - Control bit 6 enables processor, resets 1
// RULE_03 - Power down: clear processor before receiver
// RULE_04 - Power up: set receiver before processor
// RULE_05 - Status bit 7 set on rising edge
// RULE_06 - Write 1 then 0 to bit 5 clears
// RULE_07 - Status bit 6 flags marginal capture
// RULE_08 - Write 1 then 0 to bit 4 clears
// RULE_09 - Marginal flag may miss sweeps; use realignment
// RULE_10 - Status low six bits read 000111b
// RULE_11 - Bits 2,1,0 select DC-coupled inputs, reset 0
// RULE_12 - Flag held clear while clear bit high
module scc_sysref_capture_control (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   reset_n_i,
  // Register bus
  input  wire scc_pkg::scc_avmm_req_t avmm_req_i,
  output scc_pkg::scc_avmm_rsp_t      avmm_rsp_o,
  // Timing reference input as sampled
  input  wire logic                   align_input_i,
  input  wire logic                   align_marginal_i,
  // Analog and routing controls
  output logic                        align_receiver_on_o,
  output logic                        align_processor_on_o,
  output logic                        devclock_dc_coupled_sel_o,
  output logic                        align_input_dc_coupled_sel_o,
  output logic                        sync_input_dc_coupled_sel_o,
  output logic [7:0]                  control_two_o,
  // Interrupt
  output logic                        irq_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0]                ctrl;          // Control register
  logic [7:0]                ctrl_two;      // Second control register
  logic                      edge_seen_flag;        // Rising edge seen
  logic                      marginal_capture_bit;  // Marginal capture seen
  logic [1:0]                irq_stat;      // Sticky interrupt status
  logic [1:0]                irq_mask;      // Interrupt enables
  logic                      align_prev;    // Previous reference level
  logic [31:0]               rdata;         // Read data register
  logic                      rvalid;        // Read data valid
  scc_pkg::scc_bus_state_t   bus_state;     // Bus handshake state

  logic                      edge_event;    // Qualified rising edge
  logic                      marg_event;    // Qualified marginal capture
  logic                      edge_seen_clear;            // Clear bit level
  logic                      marginal_capture_clear_bit; // Clear bit level
  logic [9:0]                word_idx;      // Addressed word
  logic                      access;        // Request in progress
  logic                      wr_fire;       // Write accepted this edge
  logic                      rd_fire;       // Read accepted this edge
  logic [7:0]                status_word;   // Assembled status byte

  ////////////////////////////////////////////////////////////////////////////////
  // Decode
  assign word_idx = avmm_req_i.address[11:2];
  assign access   = avmm_req_i.read | avmm_req_i.write;
  assign wr_fire  = avmm_req_i.write && bus_state == scc_pkg::SCC_DONE;
  assign rd_fire  = avmm_req_i.read && bus_state == scc_pkg::SCC_DONE;

  // Field views of the control register
  assign align_receiver_on_o          = ctrl[scc_pkg::CTRL_RCVR_ON_BIT];   // [RULE_01]
  assign align_processor_on_o         = ctrl[scc_pkg::CTRL_PROC_ON_BIT];   // [RULE_02]
  assign edge_seen_clear              = ctrl[scc_pkg::CTRL_EDGE_CLR_BIT];
  assign marginal_capture_clear_bit   = ctrl[scc_pkg::CTRL_MARG_CLR_BIT];
  assign devclock_dc_coupled_sel_o    = ctrl[scc_pkg::CTRL_DEVICE_SAMPLE_CLOCK_DC_BIT]; // [RULE_11]
  assign align_input_dc_coupled_sel_o = ctrl[scc_pkg::CTRL_ALIGN_DC_BIT];  // [RULE_11]
  assign sync_input_dc_coupled_sel_o  = ctrl[scc_pkg::CTRL_SYNC_DC_BIT];   // [RULE_11]
  assign control_two_o                = ctrl_two;

  // Events count only while receiver and processor both run
  // Power sequencing is left to software; no ordering is enforced  [RULE_03] [RULE_04]
  assign edge_event = align_input_i && !align_prev
                      && align_receiver_on_o && align_processor_on_o;
  // Marginal timing is only judged on an edge; sweeps may slip past  [RULE_09]
  assign marg_event = edge_event && align_marginal_i;

  // Status byte with fixed low bits
  always_comb begin
    status_word = {edge_seen_flag, marginal_capture_bit, scc_pkg::STAT_FIXED_LOW}; // [RULE_10]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle then completion
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus_state <= scc_pkg::SCC_IDLE;
    end else begin
      case (bus_state)
        scc_pkg::SCC_IDLE: begin
          // Accept a new request
          if (access) begin
            bus_state <= scc_pkg::SCC_DONE;
          end
        end
        scc_pkg::SCC_DONE: begin
          // Completion takes one edge
          bus_state <= scc_pkg::SCC_IDLE;
        end
        default: begin
          bus_state <= scc_pkg::SCC_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl     <= scc_pkg::CTRL_RESET;      // [RULE_01] [RULE_02] [RULE_11]
      ctrl_two <= scc_pkg::CTRL_TWO_RESET;
    end else if (wr_fire && avmm_req_i.byteenable[0]) begin
      // Low byte lane only
      if (word_idx == scc_pkg::IDX_CTRL) begin
        ctrl <= avmm_req_i.writedata[7:0];
      end else if (word_idx == scc_pkg::IDX_CTRL_TWO) begin
        ctrl_two <= avmm_req_i.writedata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Edge history of the reference input
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      align_prev <= 1'b0;
    end else begin
      align_prev <= align_input_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Edge seen flag, held clear while its clear bit is high
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      edge_seen_flag <= 1'b0;                 // [RULE_05]
    end else if (edge_seen_clear) begin
      edge_seen_flag <= 1'b0;                 // [RULE_06] [RULE_12]
    end else if (edge_event) begin
      edge_seen_flag <= 1'b1;                 // [RULE_05]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Marginal capture flag, held clear while its clear bit is high
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      marginal_capture_bit <= 1'b0;           // [RULE_07]
    end else if (marginal_capture_clear_bit) begin
      marginal_capture_bit <= 1'b0;           // [RULE_08] [RULE_12]
    end else if (marg_event) begin
      marginal_capture_bit <= 1'b1;           // [RULE_07]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over write-one-to-clear
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_stat <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == scc_pkg::IRQ_EDGE_BIT && edge_event) || (i == scc_pkg::IRQ_MARG_BIT && marg_event)) begin
          irq_stat[i] <= 1'b1;
        end else if (wr_fire && avmm_req_i.byteenable[0] && word_idx == scc_pkg::IDX_IRQ_STAT
                     && avmm_req_i.writedata[i]) begin
          irq_stat[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt mask
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_mask <= 2'h0;
    end else if (wr_fire && avmm_req_i.byteenable[0] && word_idx == scc_pkg::IDX_IRQ_MASK) begin
      irq_mask <= avmm_req_i.writedata[1:0];
    end
  end

  // Level interrupt
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, registered while waitrequest is high
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata  <= 32'h0000_0000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= rd_fire;
      if (bus_state == scc_pkg::SCC_IDLE && avmm_req_i.read) begin
        case (word_idx)
          scc_pkg::IDX_CTRL:     rdata <= {24'h00_0000, ctrl};
          scc_pkg::IDX_STATUS:   rdata <= {24'h00_0000, status_word};
          scc_pkg::IDX_CTRL_TWO: rdata <= {24'h00_0000, ctrl_two};
          scc_pkg::IDX_IRQ_STAT: rdata <= {30'h0000_0000, irq_stat};
          scc_pkg::IDX_IRQ_MASK: rdata <= {30'h0000_0000, irq_mask};
          // Unmapped words read zero
          default:               rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Answer bundle
  always_comb begin
    avmm_rsp_o.readdata      = rdata;
    avmm_rsp_o.readdatavalid = rvalid;
    avmm_rsp_o.waitrequest   = access && bus_state == scc_pkg::SCC_IDLE;
  end

endmodule // scc_sysref_capture_control

// [testbench/scc_chk_sva.sv]
`timescale 1ns/10ps
module scc_chk (
  // Clock, reset and register bus
  input wire logic                   clk_i,
  input wire logic                   reset_n_i,
  input wire scc_pkg::scc_avmm_req_t avmm_req_i,
  input wire scc_pkg::scc_avmm_rsp_t avmm_rsp_o,
  // Reference input and controls
  input wire logic                   align_input_i,
  input wire logic                   align_marginal_i,
  input wire logic                   align_receiver_on_o,
  input wire logic                   align_processor_on_o,
  input wire logic                   devclock_dc_coupled_sel_o,
  input wire logic                   align_input_dc_coupled_sel_o,
  input wire logic                   sync_input_dc_coupled_sel_o,
  input wire logic [7:0]             control_two_o,
  input wire logic                   irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Completed control write and status read
  wire logic ctrl_wr = avmm_req_i.write && !avmm_rsp_o.waitrequest && avmm_req_i.byteenable[0]
    && avmm_req_i.address[11:2] == scc_pkg::IDX_CTRL;
  wire logic stat_rd = avmm_req_i.read && !avmm_rsp_o.waitrequest
    && avmm_req_i.address[11:2] == scc_pkg::IDX_STATUS;
  a_enables_reset: assert property ($rose(reset_n_i) |-> align_receiver_on_o && align_processor_on_o)
    else $error("enables low after reset");
  a_dc_reset: assert property ($rose(reset_n_i) |-> !devclock_dc_coupled_sel_o
    && !align_input_dc_coupled_sel_o && !sync_input_dc_coupled_sel_o) else $error("dc select after reset");
  a_irq_reset: assert property ($rose(reset_n_i) |-> !irq_o && control_two_o == scc_pkg::CTRL_TWO_RESET)
    else $error("irq or control two after reset");
  a_enables_write: assert property (ctrl_wr |=>
    align_receiver_on_o == $past(avmm_req_i.writedata[7])
    && align_processor_on_o == $past(avmm_req_i.writedata[6])) else $error("enable write lost");
  a_dc_write: assert property (ctrl_wr |=> {devclock_dc_coupled_sel_o, align_input_dc_coupled_sel_o,
    sync_input_dc_coupled_sel_o} == $past(avmm_req_i.writedata[2:0])) else $error("dc write lost");
  a_status_low: assert property (stat_rd |-> avmm_rsp_o.readdata[5:0] == 6'h07
    && avmm_rsp_o.readdata[31:8] == 24'h0) else $error("status fixed bits");
  a_wait_one: assert property ((avmm_req_i.read || avmm_req_i.write) && avmm_rsp_o.waitrequest
    |=> !avmm_rsp_o.waitrequest) else $error("wait state count");
  a_irq_fall: assert property ($fell(irq_o) |-> $past(avmm_req_i.write, 2))
    else $error("irq fell without write");
  // Read data valid pulses once, the cycle after a completed read
  a_rvalid_pulse: assert property (avmm_req_i.read && !avmm_rsp_o.waitrequest |=> avmm_rsp_o.readdatavalid)
    else $error("read data valid missing");
  a_rvalid_only: assert property (avmm_rsp_o.readdatavalid |-> $past(avmm_req_i.read && !avmm_rsp_o.waitrequest))
    else $error("read data valid without read");
endmodule // scc_chk

bind scc_sysref_capture_control scc_chk u_chk (.clk_i, .reset_n_i, .avmm_req_i, .avmm_rsp_o,
  .align_input_i, .align_marginal_i, .align_receiver_on_o, .align_processor_on_o,
  .devclock_dc_coupled_sel_o, .align_input_dc_coupled_sel_o, .sync_input_dc_coupled_sel_o,
  .control_two_o, .irq_o);

// [testbench/scc_ref_src.sv]
`timescale 1ns/10ps
// Reference source: one rising edge per fire request
module scc_ref_src (
  input wire logic clk_i,
  input wire logic fire_i,
  input wire logic dirty_i,
  output logic     ref_o = 1'b0,
  output logic     marg_o = 1'b0
);
  // Marginal line only counts on the edge, elsewhere it toggles
  always @(posedge clk_i) begin
    ref_o <= fire_i;
    marg_o <= fire_i ? dirty_i : !marg_o;
  end
endmodule // scc_ref_src

// [testbench/tb_top.sv]
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_top;
  logic clk_i, reset_n_i, fire, dirty, ref_in, marg_in, rx_on, pr_on, dc_dev, dc_ref, dc_sync, irq;
  logic [7:0] c2_o;
  scc_pkg::scc_avmm_req_t req;
  scc_pkg::scc_avmm_rsp_t rsp;
  // Counters and register model
  int errors, total_checks, seed = 32'h1a29;
  int ctrl = 'hC0, c2 = 'h80, edg, mrg, ist, msk;
  scc_sysref_capture_control dut (.clk_i, .reset_n_i, .avmm_req_i(req), .avmm_rsp_o(rsp),
    .align_input_i(ref_in), .align_marginal_i(marg_in), .align_receiver_on_o(rx_on),
    .align_processor_on_o(pr_on), .devclock_dc_coupled_sel_o(dc_dev),
    .align_input_dc_coupled_sel_o(dc_ref), .sync_input_dc_coupled_sel_o(dc_sync),
    .control_two_o(c2_o), .irq_o(irq));
  scc_ref_src u_src (.clk_i, .fire_i(fire), .dirty_i(dirty), .ref_o(ref_in), .marg_o(marg_in));
  initial begin
    clk_i = 0;
    forever #4 clk_i = ~clk_i;
  end
  // Expected read value
  function automatic logic [31:0] exp_rd(logic [11:0] a);
    case (a)
      12'h0C0: return ctrl;
      12'h0C4: return edg * 128 + mrg * 64 + 7;
      12'h0C8: return c2;
      12'h0E0: return ist;
      12'h0E4: return msk;
      default: return 0;
    endcase
  endfunction
  // One bus transfer, held until waitrequest is low
  task automatic bus(logic w, logic [11:0] a, logic [7:0] d, logic [3:0] be);
    @(posedge clk_i);
    req <= '{a, !w, w, {24'($random(seed)), d}, be};
    // Request stands until the rising edge that samples waitrequest low
    do @(posedge clk_i); while (rsp.waitrequest !== 1'b0);
    if (!w) `CHK(rsp.readdata, exp_rd(a))
    if (w && be[0]) begin
      if (a == 12'h0C0) ctrl = d;
      if (a == 12'h0C8) c2 = d;
      if (a == 12'h0E0) ist &= ~d;
      if (a == 12'h0E4) msk = d;
      if (ctrl[5]) edg = 0;
      if (ctrl[4]) mrg = 0;
    end
    // Released at the completing edge itself
    req.read <= 0;
    req.write <= 0;
  endtask
  // One reference edge, then outputs compared
  task automatic pulse(logic dt);
    @(posedge clk_i);
    fire <= 1;
    dirty <= dt;
    @(posedge clk_i);
    fire <= 0;
    repeat (4) @(posedge clk_i);
    if (ctrl[7] && ctrl[6]) begin
      ist |= 1 | dt * 2;
      if (!ctrl[5]) edg = 1;
      if (!ctrl[4] && dt) mrg = 1;
    end
    `CHK({rx_on, pr_on, dc_dev, dc_ref, dc_sync, irq, c2_o}, {ctrl[7:6], ctrl[2:0], (ist & msk) != 0, c2[7:0]})
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    report_and_stop;
  end
  // Main sequence
  initial begin
    reset_n_i = 0;
    fire = 0;
    dirty = 0;
    req = '0;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1;
    for (int i = 0; i < 6; i++) bus(0, 12'h0C0 + 12'(i * 4), 0, 0);
    pulse(0);
    bus(1, 12'h0C8, 8'h5A, 1);
    bus(1, 12'h0C0, 8'h0F, 0);
    bus(0, 12'h0C0, 0, 0);
    bus(1, 12'h0E4, 3, 1);
    for (int i = 0; i < 4; i++) begin
      bus(1, 12'h0C0, 8'hC0 | 8'($random(seed) & 7), 1);
      pulse(i[0]);
      bus(0, 12'h0C4, 0, 0);
    end
    bus(1, 12'h0C0, 8'hE0, 1);
    pulse(1);
    bus(0, 12'h0C4, 0, 0);
    bus(1, 12'h0C0, 8'hD0, 1);
    bus(0, 12'h0C4, 0, 0);
    bus(1, 12'h0C0, 8'hC0, 1);
    pulse(1);
    bus(0, 12'h0C4, 0, 0);
    bus(1, 12'h0E0, 3, 1);
    bus(0, 12'h0E0, 0, 0);
    `CHK(irq, 1'b0)
    bus(1, 12'h0C0, 8'h80, 1);
    bus(1, 12'h0C0, 8'h00, 1);
    pulse(0);
    bus(0, 12'h0E0, 0, 0);
    bus(1, 12'h0C0, 8'h80, 1);
    bus(1, 12'h0C0, 8'hC0, 1);
    pulse(0);
    bus(1, 12'h0E4, 0, 1);
    pulse(1);
    report_and_stop;
  end
endmodule // tb_top
